// *** pmc_pkg.sv ***
// pmc_pkg: constants and types for the power mode controller
// assumes a 125 MHz reference clock and plain-port control
package pmc_pkg;

    localparam int        PMC_CLK_MHZ     = 125;
    localparam int        PMC_NSUB        = 8;
    localparam int        PMC_CPU_BIT     = 0;
    localparam int        PMC_SLEEP_KEEP  = 1;
    localparam int        PMC_SLEEP_US    = 15;
    localparam int        PMC_HIB_US      = 100;
    localparam int        PMC_SLEEP_CYC   = PMC_SLEEP_US * PMC_CLK_MHZ;
    localparam int        PMC_HIB_CYC     = PMC_HIB_US * PMC_CLK_MHZ - 1;
    localparam int        PMC_CNT_W       = 14;
    localparam int        PMC_BUZZ_PER    = 64;
    localparam int        PMC_BUZZ_W      = 6;
    localparam logic [7:0] PMC_TMPL_RST   = 8'hFF;
    localparam logic [7:0] PMC_SLP_MASK   = 8'h02;

    // wake source index: comparator, pin unit, two-wire, rtc, timewheel, lvd
    localparam int        PMC_NWAKE       = 6;
    localparam int        PMC_WK_PIN      = 1;

    localparam logic [1:0] PMC_REQ_SLEEP  = 2'h1;
    localparam logic [1:0] PMC_REQ_HIB    = 2'h2;
    localparam logic [1:0] PMC_REQ_ALT    = 2'h3;

    typedef enum logic [5:0] {
        PMC_ACTIVE = 6'h01,
        PMC_ALT    = 6'h02,
        PMC_SLEEP  = 6'h04,
        PMC_HIB    = 6'h08,
        PMC_WK_SLP = 6'h10,
        PMC_WK_HIB = 6'h20
    } pmc_state_type;

endpackage : pmc_pkg

// *** pmc_ctrl.sv ***
// pmc_ctrl: global power mode sequencer with per-subsystem gating
// assumes wake and request inputs are synchronous to i_ref_clk
//
// Behaviour
// - four modes: active, alternate, sleep, hibernate
// - active template bits enable each subsystem
// - sleep forces most subsystems off
// - hibernate retains state, stops clocks, pin wake
// - active via wake/reset; interrupts wake
// - alternate entered by write, exits on interrupt
// - sleep buzzes regulators, low-speed clocks, wakes
// - hibernate: hibernate regulator only, pin wake
// - sleep resume within 15 us
// - hibernate resume under 100 us
// - disabled subsystem: clock gated, bias cut
// - cpu may self-disable, returns at wakeup
// - wakeup forces active mode and cpu on
// - active mode after boot
// - hibernate holds pin outputs and pin config
// - regulators disableable when externally supplied
// - wake from enabled interrupt or reset
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl
    import pmc_pkg::*;
(
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    // mode request
    input  wire logic                 i_req_valid,
    input  wire logic [1:0]           i_req_mode,
    input  wire logic                 i_bus_busy,
    // templates
    input  wire logic [PMC_NSUB-1:0]  i_act_tmpl_wr,
    input  wire logic [PMC_NSUB-1:0]  i_act_tmpl_din,
    input  wire logic [PMC_NSUB-1:0]  i_alt_tmpl_wr,
    input  wire logic [PMC_NSUB-1:0]  i_alt_tmpl_din,
    // wake sources and interrupts
    input  wire logic [PMC_NWAKE-1:0] i_wake_src,
    input  wire logic [PMC_NWAKE-1:0] i_wake_en,
    input  wire logic                 i_irq_any,
    // external regulation
    input  wire logic                 i_ext_dig_reg,
    input  wire logic                 i_ext_ana_reg,
    // mode and gating outputs
    output logic [3:0]                o_mode,
    output logic [PMC_NSUB-1:0]       o_clk_en,
    output logic [PMC_NSUB-1:0]       o_bias_en,
    output logic                      o_cpu_en,
    output logic                      o_lowspeed_only,
    output logic                      o_dig_reg_en,
    output logic                      o_ana_reg_en,
    output logic                      o_buzz,
    output logic                      o_hib_reg_en,
    output logic                      o_pin_hold,
    output logic                      o_wake_pulse
);

    pmc_state_type            state_q;
    pmc_state_type            state_d;
    logic [PMC_NSUB-1:0]      act_tmpl_q;
    logic [PMC_NSUB-1:0]      alt_tmpl_q;
    logic [PMC_CNT_W-1:0]     cnt_q;
    logic [PMC_BUZZ_W-1:0]    buzz_q;
    logic                     cpu_force_q;
    logic                     wake_slp;
    logic                     wake_pin;
    logic                     wake_run;
    logic                     req_ok;
    logic [PMC_NSUB-1:0]      en_d;
    logic [PMC_NSUB-1:0]      en_q;

    // applies per-bit template writes
    function automatic logic [PMC_NSUB-1:0] tmpl_upd(
        input logic [PMC_NSUB-1:0] cur,
        input logic [PMC_NSUB-1:0] wr,
        input logic [PMC_NSUB-1:0] din
    );
        tmpl_upd = (cur & ~wr) | (din & wr);
    endfunction : tmpl_upd

    // wake qualification
    assign wake_slp = |(i_wake_src & i_wake_en);
    assign wake_pin = i_wake_src[PMC_WK_PIN] & i_wake_en[PMC_WK_PIN];
    assign wake_run = i_irq_any | wake_slp;
    assign req_ok   = i_req_valid & ~i_bus_busy;

    // templates, bitwise edits at any time
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            act_tmpl_q <= PMC_TMPL_RST;
            alt_tmpl_q <= PMC_TMPL_RST;
        end else begin
            act_tmpl_q <= tmpl_upd(act_tmpl_q, i_act_tmpl_wr, i_act_tmpl_din);
            alt_tmpl_q <= tmpl_upd(alt_tmpl_q, i_alt_tmpl_wr, i_alt_tmpl_din);
        end
    end

    // mode sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PMC_ACTIVE: begin
                if (req_ok) begin
                    if (i_req_mode == PMC_REQ_SLEEP) begin
                        state_d = PMC_SLEEP;
                    end else if (i_req_mode == PMC_REQ_HIB) begin
                        state_d = PMC_HIB;
                    end else if (i_req_mode == PMC_REQ_ALT) begin
                        state_d = PMC_ALT;
                    end
                end
            end
            PMC_ALT: begin
                if (wake_run) begin
                    state_d = PMC_ACTIVE;
                end else if (req_ok && i_req_mode == PMC_REQ_SLEEP) begin
                    state_d = PMC_SLEEP;
                end else if (req_ok && i_req_mode == PMC_REQ_HIB) begin
                    state_d = PMC_HIB;
                end
            end
            PMC_SLEEP: begin
                if (wake_slp) begin
                    state_d = PMC_WK_SLP;
                end
            end
            PMC_HIB: begin
                if (wake_pin) begin
                    state_d = PMC_WK_HIB;
                end
            end
            PMC_WK_SLP: begin
                if (cnt_q == PMC_CNT_W'(PMC_SLEEP_CYC - 1)) begin
                    state_d = PMC_ACTIVE;
                end
            end
            PMC_WK_HIB: begin
                if (cnt_q == PMC_CNT_W'(PMC_HIB_CYC - 1)) begin
                    state_d = PMC_ACTIVE;
                end
            end
            default: begin
                state_d = PMC_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= PMC_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // resume timer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || state_q != state_d) begin
            cnt_q <= '0;
        end else if (state_q == PMC_WK_SLP || state_q == PMC_WK_HIB) begin
            cnt_q <= cnt_q + PMC_CNT_W'(1);
        end
    end

    // regulator buzz timer in sleep
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || state_q != PMC_SLEEP) begin
            buzz_q <= '0;
        end else begin
            buzz_q <= buzz_q + PMC_BUZZ_W'(1);
        end
    end

    // cpu forced on after wakeup until firmware rewrites its bit
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cpu_force_q <= 1'b0;
        end else if (state_d == PMC_ACTIVE && state_q != PMC_ACTIVE
                     && state_q != PMC_ALT) begin
            cpu_force_q <= 1'b1;
        end else if (state_q == PMC_ALT && state_d == PMC_ACTIVE) begin
            cpu_force_q <= 1'b1;
        end else if (i_act_tmpl_wr[PMC_CPU_BIT]) begin
            cpu_force_q <= 1'b0;
        end
    end

    // subsystem enables per mode
    always_comb begin
        en_d = '0;
        unique case (state_q)
            PMC_ACTIVE: en_d = act_tmpl_q;
            PMC_ALT:    en_d = alt_tmpl_q;
            PMC_SLEEP:  en_d = PMC_SLP_MASK;
            default:    en_d = '0;
        endcase
        if (cpu_force_q && state_q == PMC_ACTIVE) begin
            en_d[PMC_CPU_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            en_q <= PMC_TMPL_RST;
        end else begin
            en_q <= en_d;
        end
    end

    // outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_mode          <= 4'h1;
            o_lowspeed_only <= 1'b0;
            o_dig_reg_en    <= 1'b1;
            o_ana_reg_en    <= 1'b1;
            o_buzz          <= 1'b0;
            o_hib_reg_en    <= 1'b1;
            o_pin_hold      <= 1'b0;
            o_wake_pulse    <= 1'b0;
        end else begin
            o_mode          <= state_d[3:0] | {1'b0, state_d[5], state_d[4],
                                               state_d[4] | state_d[5]};
            o_lowspeed_only <= state_d == PMC_SLEEP;
            o_dig_reg_en    <= ~i_ext_dig_reg
                               && (state_d == PMC_ACTIVE || state_d == PMC_ALT
                                   || state_d == PMC_WK_SLP || state_d == PMC_WK_HIB);
            o_ana_reg_en    <= ~i_ext_ana_reg
                               && (state_d == PMC_ACTIVE || state_d == PMC_ALT
                                   || state_d == PMC_WK_SLP || state_d == PMC_WK_HIB);
            o_buzz          <= state_d == PMC_SLEEP && buzz_q == '0;
            o_hib_reg_en    <= 1'b1;
            o_pin_hold      <= state_d == PMC_HIB || state_d == PMC_WK_HIB;
            o_wake_pulse    <= state_d == PMC_ACTIVE && state_q != PMC_ACTIVE;
        end
    end

    assign o_clk_en  = en_q;
    assign o_bias_en = en_q;
    assign o_cpu_en  = en_q[PMC_CPU_BIT];

    // cycles spent resuming, watched by the resume checks
    logic [PMC_CNT_W-1:0]     age_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !(state_q == PMC_WK_SLP || state_q == PMC_WK_HIB)) begin
            age_q <= '0;
        end else begin
            age_q <= age_q + PMC_CNT_W'(1);
        end
    end

    // checks
    a_sleep_resume_time: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_WK_SLP |-> age_q < PMC_CNT_W'(PMC_SLEEP_CYC))
        else $error("sleep resume too slow");
    a_hib_resume_time: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_WK_HIB |-> age_q < PMC_CNT_W'(PMC_HIB_CYC))
        else $error("hibernate resume too slow");
    a_hib_pin_only: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_HIB && !wake_pin |=> state_q == PMC_HIB)
        else $error("hibernate left without pin wake");
    a_sleep_forces_off: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_SLEEP |=> en_q == PMC_SLP_MASK)
        else $error("sleep enables wrong");
    a_wake_cpu_on: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(state_q == PMC_ACTIVE) ##1 !i_act_tmpl_wr[PMC_CPU_BIT] |-> o_cpu_en)
        else $error("cpu not enabled after wake");
    a_alt_irq_exit: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ALT && wake_run |=> state_q == PMC_ACTIVE)
        else $error("alternate not exited on interrupt");
    a_busy_blocks_req: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ACTIVE && i_bus_busy |=> state_q == PMC_ACTIVE)
        else $error("request taken while busy");
    a_hib_holds_pins: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_HIB |=> o_pin_hold && o_clk_en == '0)
        else $error("hibernate pins not held");
    a_active_tmpl: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ACTIVE && $stable(state_q) && !cpu_force_q
        |=> en_q == $past(act_tmpl_q))
        else $error("active template not applied");
    a_alt_tmpl_use: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ALT && $stable(state_q) |=> en_q == $past(alt_tmpl_q))
        else $error("alternate template not applied");
    a_sleep_lowspeed: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_lowspeed_only == (state_q == PMC_SLEEP))
        else $error("low-speed flag wrong");
    a_buzz_in_sleep: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_buzz |-> state_q == PMC_SLEEP)
        else $error("buzz outside sleep");
    a_sleep_wake_exit: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_SLEEP && wake_slp |=> state_q == PMC_WK_SLP)
        else $error("sleep wake not taken");
    a_sleep_stays: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_SLEEP && !wake_slp |=> state_q == PMC_SLEEP)
        else $error("sleep left without wake");
    a_hib_wake_exit: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_HIB && wake_pin |=> state_q == PMC_WK_HIB)
        else $error("hibernate pin wake not taken");
    a_hib_regs_off: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_HIB |-> o_hib_reg_en && !o_dig_reg_en && !o_ana_reg_en)
        else $error("hibernate regulators wrong");
    a_ext_dig_off: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_ext_dig_reg |=> !o_dig_reg_en)
        else $error("digital regulator not disabled");
    a_ext_ana_off: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_ext_ana_reg |=> !o_ana_reg_en)
        else $error("analogue regulator not disabled");
    a_sleep_bias_off: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_SLEEP |=> o_bias_en == PMC_SLP_MASK)
        else $error("sleep bias enables wrong");
    a_wake_pulse_one: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wake_pulse |=> !o_wake_pulse)
        else $error("wake pulse too long");
    a_wake_pulse_mode: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_wake_pulse |-> o_mode == 4'h1)
        else $error("wake pulse outside active");
    a_no_req_keeps: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ACTIVE && !i_req_valid |=> state_q == PMC_ACTIVE)
        else $error("active left without request");
    a_req_zero_ignored: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ACTIVE && i_req_mode == 2'h0 |=> state_q == PMC_ACTIVE)
        else $error("ignored request changed mode");
    a_alt_by_write: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        state_q == PMC_ACTIVE && !req_ok |=> state_q == PMC_ACTIVE)
        else $error("mode left without write");
    a_cpu_force_on: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cpu_force_q && state_q == PMC_ACTIVE |=> o_cpu_en)
        else $error("cpu not held on after wake");

endmodule : pmc_ctrl
`default_nettype wire

// *** pmc_wake_model.sv ***
// pmc_wake_model: pending wake requests of the peripherals
// assumes fire commands change off the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_model (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // fire command
    input  wire logic       i_fire,
    input  wire logic [2:0] i_fire_idx,
    // controller mode
    input  wire logic [3:0] i_mode,
    // level wake requests
    output logic      [5:0] o_wake_src
);
    logic [5:0] pend_q;

    // request stays pending until active mode is back
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || i_mode == 4'h1) begin
            pend_q <= 6'h00;
        end else if (i_fire) begin
            pend_q <= pend_q | (6'h01 << i_fire_idx);
        end
    end
    assign o_wake_src = pend_q;
endmodule : pmc_wake_model
`default_nettype wire

// *** pmc_ctrl_test.sv ***
// pmc_ctrl_test: self-checking bench for the power mode controller
// assumes pmc_ctrl and pmc_wake_model compiled beforehand
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl_test;
    import pmc_pkg::*;
    logic       clk, rst, req_v, busy, irq, fire, ext_d, ext_a;
    logic       cpu_en, lowspd, dig_en, ana_en, buzz, hib_en, hold;
    logic       wpulse, seen;
    logic [1:0] req_m;
    logic [2:0] fidx;
    logic [3:0] mode;
    logic [5:0] wsrc, wen;
    logic [7:0] act_wr, act_d, alt_wr, alt_d, clk_en, bias_en;
    int         n_fail, comparisons, n;

    pmc_ctrl pmc_ctrl_inst (.i_ref_clk(clk), .i_rst(rst),
        .i_req_valid(req_v), .i_req_mode(req_m), .i_bus_busy(busy),
        .i_act_tmpl_wr(act_wr), .i_act_tmpl_din(act_d),
        .i_alt_tmpl_wr(alt_wr), .i_alt_tmpl_din(alt_d),
        .i_wake_src(wsrc), .i_wake_en(wen), .i_irq_any(irq),
        .i_ext_dig_reg(ext_d), .i_ext_ana_reg(ext_a), .o_mode(mode),
        .o_clk_en(clk_en), .o_bias_en(bias_en), .o_cpu_en(cpu_en),
        .o_lowspeed_only(lowspd), .o_dig_reg_en(dig_en),
        .o_ana_reg_en(ana_en), .o_buzz(buzz), .o_hib_reg_en(hib_en),
        .o_pin_hold(hold), .o_wake_pulse(wpulse));
    pmc_wake_model pmc_wake_model_inst (.i_ref_clk(clk), .i_rst(rst),
        .i_fire(fire), .i_fire_idx(fidx), .i_mode(mode),
        .o_wake_src(wsrc));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("fails=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic req(input logic [1:0] m, input logic b);
        @(negedge clk);
        req_v = 1'b1;
        req_m = m;
        busy  = b;
        @(negedge clk);
        req_v = 1'b0;
        busy  = 1'b0;
        repeat (3) @(negedge clk);
    endtask : req

    task automatic wr_act(input logic [7:0] m, input logic [7:0] d);
        @(negedge clk);
        act_wr = m;
        act_d  = d;
        @(negedge clk);
        act_wr = 8'h00;
        repeat (2) @(negedge clk);
    endtask : wr_act

    task automatic fire_src(input logic [2:0] idx);
        @(negedge clk);
        fire = 1'b1;
        fidx = idx;
        @(negedge clk);
        fire = 1'b0;
    endtask : fire_src

    task automatic wait_act(input int lim);
        n    = 0;
        seen = 1'b0;
        while (mode !== 4'h1 && n < lim) begin
            @(negedge clk);
            n++;
            if (wpulse === 1'b1) seen = 1'b1;
        end
        @(negedge clk);
        if (wpulse === 1'b1) seen = 1'b1;
    endtask : wait_act

    task automatic t_boot;
        chk({4'h0, mode}, 8'h01);
        chk(clk_en, 8'hFF);
        chk({7'h0, hold}, 8'h00);
    endtask : t_boot

    task automatic t_tmpl;
        wr_act(8'h08, 8'h00);
        chk(clk_en, 8'hF7);
        chk(bias_en, 8'hF7);
        chk({4'h0, mode}, 8'h01);
        wr_act(8'h01, 8'h00);
        chk({7'h0, cpu_en}, 8'h00);
        ext_d = 1'b1;
        ext_a = 1'b1;
        repeat (2) @(negedge clk);
        chk({6'h0, dig_en, ana_en}, 8'h00);
        ext_d = 1'b0;
        ext_a = 1'b0;
        req(PMC_REQ_SLEEP, 1'b1);
        chk({4'h0, mode}, 8'h01);
        req(2'h0, 1'b0);
        chk({4'h0, mode}, 8'h01);
    endtask : t_tmpl

    task automatic t_sleep;
        req(PMC_REQ_SLEEP, 1'b0);
        chk({4'h0, mode}, 8'h04);
        chk(clk_en, PMC_SLP_MASK);
        chk({7'h0, lowspd}, 8'h01);
        n = 0;
        while (buzz !== 1'b1 && n < 70) begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, buzz}, 8'h01);
        fire_src(3'h0);
        repeat (100) @(negedge clk);
        chk({4'h0, mode}, 8'h04);
        fire_src(3'h3);
        wait_act(1900);
        chk({7'h0, n <= 1880}, 8'h01);
        chk({6'h0, cpu_en, seen}, 8'h03);
        chk(clk_en, 8'hF7);
    endtask : t_sleep

    task automatic t_hib;
        req(PMC_REQ_HIB, 1'b0);
        chk({4'h0, mode}, 8'h08);
        chk({5'h0, hib_en, hold, dig_en}, 8'h06);
        chk(clk_en, 8'h00);
        fire_src(3'h3);
        repeat (100) @(negedge clk);
        chk({4'h0, mode}, 8'h08);
        fire_src(3'h1);
        wait_act(12600);
        chk({7'h0, n <= 12503}, 8'h01);
        chk({7'h0, hold}, 8'h00);
    endtask : t_hib

    task automatic t_alt;
        @(negedge clk);
        alt_wr = 8'hFF;
        alt_d  = 8'h3C;
        @(negedge clk);
        alt_wr = 8'h00;
        req(PMC_REQ_ALT, 1'b0);
        chk({4'h0, mode}, 8'h02);
        chk(clk_en, 8'h3C);
        @(negedge clk);
        irq = 1'b1;
        @(negedge clk);
        irq = 1'b0;
        wait_act(10);
        chk({3'h0, mode, cpu_en}, 8'h03);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        chk({4'h0, mode}, 8'h01);
        chk(clk_en, 8'hFF);
    endtask : t_alt

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #400000;
        n_fail++;
        finish_test();
    end

    initial begin
        {rst, req_v, busy, irq, fire, ext_d, ext_a} = 7'h40;
        {req_m, fidx, act_wr, act_d, alt_wr, alt_d} = 37'h0;
        wen = 6'h3E;
        n_fail = 0;
        comparisons = 0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_boot();
        t_tmpl();
        t_sleep();
        t_hib();
        t_alt();
        finish_test();
    end
endmodule : pmc_ctrl_test
`default_nettype wire
